// File: dsau_pkg.sv
// Package with constants and carrier types for the data space access unit
package dsau_pkg;
    localparam int unsigned DSAU_DATA_W      = 16;
    localparam int unsigned DSAU_ADDR_W      = 16;
    localparam int unsigned DSAU_PAGE_W      = 8;
    localparam int unsigned DSAU_XADDR_W     = 24;
    localparam int unsigned DSAU_NEAR_W      = 13;
    localparam int unsigned DSAU_BYTE_W      = 8;
    localparam int unsigned DSAU_LANE_HI_POS = 8;
    localparam logic [15:0] DSAU_SPECIAL_LO  = 16'h0000;
    localparam logic [15:0] DSAU_SPECIAL_HI  = 16'h0fff;
    localparam logic [15:0] DSAU_RAM_LO      = 16'h1000;
    localparam logic [15:0] DSAU_RAM_HI      = 16'hcfff;
    localparam logic [15:0] DSAU_INC_BYTE    = 16'h0001;
    localparam logic [15:0] DSAU_INC_WORD    = 16'h0002;
    localparam logic [7:0]  DSAU_PAGE_RST    = 8'h00;
    localparam logic [15:0] DSAU_WORD_RST    = 16'h0000;
    localparam logic [1:0]  DSAU_STRB_NONE   = 2'h0;
    localparam logic [1:0]  DSAU_STRB_LO     = 2'h1;
    localparam logic [1:0]  DSAU_STRB_HI     = 2'h2;
    localparam logic [1:0]  DSAU_STRB_BOTH   = 2'h3;

    typedef enum logic [1:0] {
        DSAU_MODE_DIRECT16,
        DSAU_MODE_NEAR13,
        DSAU_MODE_INDIRECT,
        DSAU_MODE_POSTINC
    } dsau_mode_t;

    typedef enum logic [1:0] {
        DSAU_EXT_NONE,
        DSAU_EXT_SIGN,
        DSAU_EXT_ZERO
    } dsau_ext_t;

    // Access request from the core
    typedef struct packed {
        logic       valid;
        logic       write;
        logic       is_byte;
        dsau_mode_t mode;
        logic [15:0] direct_addr;
        logic [15:0] source_work_reg;
        logic [15:0] wdata;
    } dsau_req_t;

    // Memory side request
    typedef struct packed {
        logic        rd;
        logic [1:0]  wr_strb;
        logic [23:0] xaddr;
        logic [15:0] word_addr;
        logic [15:0] wdata;
    } dsau_mem_t;
endpackage

// File: dsau_lane_sel.sv
// Byte lane selector and working register merge/extend logic
`timescale 1ns/100ps
module dsau_lane_sel
    import dsau_pkg::*;
(
    input  wire logic [15:0] word_i,
    input  wire logic        byte_odd_i,
    input  wire logic        is_byte_i,
    input  wire logic [15:0] dest_old_i,
    input  wire dsau_ext_t   ext_i,
    output logic      [15:0] merged_o
);
    logic [7:0] sel_byte;

    always_comb begin
        // Pick the byte by address lsb, place on low lane
        sel_byte = byte_odd_i ? word_i[15:8] : word_i[7:0];
        if (ext_i == DSAU_EXT_SIGN) begin
            merged_o = {{DSAU_BYTE_W{dest_old_i[7]}}, dest_old_i[7:0]};
        end else if (ext_i == DSAU_EXT_ZERO) begin
            merged_o = {8'h00, dest_old_i[7:0]};
        end else if (is_byte_i) begin
            merged_o = {dest_old_i[15:8], sel_byte};
        end else begin
            merged_o = word_i;
        end
    end
endmodule

// File: dsau_core.sv
// Data space access unit: address generation, lanes, alignment trap
`timescale 1ns/100ps
module dsau_core
    import dsau_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        clk_en_i,
    input  wire dsau_req_t   req_i,
    input  wire logic [7:0]  read_page_reg_i,
    input  wire logic [7:0]  write_page_reg_i,
    input  wire logic [15:0] mem_rdata_i,
    input  wire logic        special_hit_i,
    input  wire logic [15:0] dest_old_i,
    input  wire dsau_ext_t   ext_i,
    output dsau_mem_t        mem_o,
    output logic [15:0]      rdata_o,
    output logic             rvalid_o,
    output logic [15:0]      work_reg_o,
    output logic [15:0]      next_pointer_o,
    output logic             pointer_we_o,
    output logic             addr_error_trap_o
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [1:0] {
        DSAU_ST_IDLE,
        DSAU_ST_READ,
        DSAU_ST_TRAP
    } dsau_state_t;

    // All state of the unit in one record
    typedef struct packed {
        dsau_state_t  st;
        dsau_mem_t    mem;
        logic [15:0]  rdata;
        logic         rvalid;
        logic [15:0]  work_reg;
        logic [15:0]  pointer;
        logic         pointer_we;
        logic         trap;
        logic         rd_byte;
        logic         rd_odd;
        logic         rd_impl;
        logic         rd_special;
        logic         rd_misalign;
    } dsau_state_s_t;

    dsau_state_s_t q;
    dsau_state_s_t next_q;
    logic [15:0]   effective_address;
    logic          misalign;
    logic          implemented;
    logic          in_special;
    logic [15:0]   read_word;
    logic [15:0]   merged;

    // Request side
    dsau_ext_t     ext_now;
    logic          take_req;
    logic          write_allowed;
    logic          bump_ptr;
    logic          in_ram;
    logic [15:0]   near_address;
    logic [15:0]   word_address;
    logic [15:0]   step;
    logic [15:0]   bumped_pointer;

    // Write side
    logic [23:0]   write_xaddr;
    logic [1:0]    lane_strb;
    logic [15:0]   lane_wdata;

    // Read side
    logic [23:0]   read_xaddr;
    logic          read_zero;
    dsau_state_t   answer_st;

    // ----------------------------------------
    // Address generator
    // ----------------------------------------
    always_comb begin
        effective_address = req_i.direct_addr;
        if (req_i.mode == DSAU_MODE_NEAR13) begin
            effective_address = near_address;
        end else if (req_i.mode == DSAU_MODE_INDIRECT || req_i.mode == DSAU_MODE_POSTINC) begin
            effective_address = req_i.source_work_reg;
        end
    end

    // ----------------------------------------
    // Region and alignment decode
    // ----------------------------------------
    always_comb begin
        // Byte accesses may use any address
        misalign = 1'b0;
        if (!req_i.is_byte) begin
            misalign = effective_address[0];
        end
        in_special  = effective_address <= DSAU_SPECIAL_HI;
        in_ram      = (effective_address >= DSAU_RAM_LO) && (effective_address <= DSAU_RAM_HI);
        implemented = in_special || in_ram;
    end

    // ----------------------------------------
    // Request decode
    // ----------------------------------------
    always_comb begin
        // Requests outside idle are dropped
        take_req      = req_i.valid && (q.st == DSAU_ST_IDLE);
        write_allowed = take_req && req_i.write && !misalign;
        bump_ptr      = take_req && (req_i.mode == DSAU_MODE_POSTINC);
    end

    // ----------------------------------------
    // Near field and page join
    // ----------------------------------------
    // The short field reaches only the low 8 Kbytes
    assign near_address = {3'h0, req_i.direct_addr[DSAU_NEAR_W-1:0]};
    // Memory always sees the even word
    assign word_address = {effective_address[15:1], 1'b0};
    // Each generator joins its own page
    assign read_xaddr  = {read_page_reg_i, effective_address};
    assign write_xaddr = {write_page_reg_i, effective_address};

    // ----------------------------------------
    // Write lanes
    // ----------------------------------------
    // Shared word decode, one strobe per lane
    for (genvar g = 0; g < 2; g++) begin : g_lane
        // Aligned words hit both lanes in one cycle, misaligned words hit none
        assign lane_strb[g] = write_allowed && (!req_i.is_byte || (effective_address[0] == 1'(g)));
        // Byte data mirrored on both lanes
        assign lane_wdata[g*DSAU_BYTE_W +: DSAU_BYTE_W] = req_i.is_byte ? req_i.wdata[7:0]
                                                        : req_i.wdata[g*DSAU_BYTE_W +: DSAU_BYTE_W];
    end

    // ----------------------------------------
    // Post-increment pointer
    // ----------------------------------------
    always_comb begin
        // Bytes step by one, words by two
        step = DSAU_INC_WORD;
        if (req_i.is_byte) begin
            step = DSAU_INC_BYTE;
        end
        bumped_pointer = req_i.source_work_reg + step;
    end

    // ----------------------------------------
    // Extend gate
    // ----------------------------------------
    always_comb begin
        // Extends act only in idle so a read answer is never overwritten
        ext_now = DSAU_EXT_NONE;
        if (q.st == DSAU_ST_IDLE) begin
            ext_now = ext_i;
        end
    end

    // ----------------------------------------
    // Read data path
    // ----------------------------------------
    always_comb begin
        read_zero = 1'b0;
        if (!q.rd_impl) begin
            read_zero = 1'b1;
        end else if (q.rd_special && !special_hit_i) begin
            read_zero = 1'b1;
        end
        read_word = read_zero ? DSAU_WORD_RST : mem_rdata_i;
    end

    // ----------------------------------------
    // Lane selector
    // ----------------------------------------
    dsau_lane_sel u_lane (
        .word_i     (read_word),
        .byte_odd_i (q.rd_odd),
        .is_byte_i  (q.rd_byte),
        .dest_old_i (dest_old_i),
        .ext_i      (ext_now),
        .merged_o   (merged)
    );

    // ----------------------------------------
    // Read answer
    // ----------------------------------------
    always_comb begin
        // A misaligned read finishes first, then traps
        answer_st = DSAU_ST_IDLE;
        if (q.rd_misalign) begin
            answer_st = DSAU_ST_TRAP;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_q            = q;
        next_q.mem.rd     = 1'b0;
        next_q.mem.wr_strb = DSAU_STRB_NONE;
        next_q.rvalid     = 1'b0;
        next_q.pointer_we = 1'b0;
        next_q.trap       = 1'b0;
        case (q.st)
            DSAU_ST_IDLE: begin
                if (ext_now != DSAU_EXT_NONE) begin
                    next_q.work_reg = merged;
                end
                if (req_i.valid) begin
                    next_q.mem.word_addr = word_address;
                    if (bump_ptr) begin
                        next_q.pointer    = bumped_pointer;
                        next_q.pointer_we = 1'b1;
                    end
                    if (req_i.write) begin
                        // Write generator uses the write page
                        next_q.mem.xaddr   = write_xaddr;
                        next_q.mem.wr_strb = lane_strb;
                        if (misalign) begin
                            next_q.st = DSAU_ST_TRAP;
                        end else begin
                            next_q.mem.wdata = lane_wdata;
                        end
                    end else begin
                        // Read generator uses the read page
                        next_q.mem.xaddr   = read_xaddr;
                        next_q.mem.rd      = 1'b1;
                        next_q.rd_byte     = req_i.is_byte;
                        next_q.rd_odd      = effective_address[0];
                        next_q.rd_impl     = implemented;
                        next_q.rd_special  = in_special;
                        next_q.rd_misalign = misalign;
                        next_q.st          = DSAU_ST_READ;
                    end
                end
            end
            DSAU_ST_READ: begin
                // Read completes even when misaligned, trap follows
                next_q.rdata    = merged;
                next_q.work_reg = merged;
                next_q.rvalid   = 1'b1;
                next_q.st       = answer_st;
            end
            DSAU_ST_TRAP: begin
                next_q.trap = 1'b1;
                next_q.st   = DSAU_ST_IDLE;
            end
            default: begin
                // Unused code falls back to idle
                next_q.st = DSAU_ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            q                  <= '0;
            q.st               <= DSAU_ST_IDLE;
            q.mem.xaddr        <= {DSAU_PAGE_RST, DSAU_WORD_RST};
        end else if (clk_en_i) begin
            q <= next_q;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Every output is a register bit
    assign mem_o             = q.mem;
    assign rdata_o           = q.rdata;
    assign rvalid_o          = q.rvalid;
    assign work_reg_o        = q.work_reg;
    assign next_pointer_o    = q.pointer;
    assign pointer_we_o      = q.pointer_we;
    assign addr_error_trap_o = q.trap;
endmodule

// File: dsau_core_asserts.sv
// Port checker for the data space access unit
`timescale 1ns/100ps
module dsau_core_chk
    import dsau_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        clk_en_i,
    input  wire dsau_req_t   req_i,
    input  wire logic [7:0]  read_page_reg_i,
    input  wire logic [7:0]  write_page_reg_i,
    input  wire dsau_mem_t   mem_o,
    input  wire logic [15:0] rdata_o,
    input  wire logic        rvalid_o,
    input  wire logic        addr_error_trap_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i || !clk_en_i);
    logic wr;
    assign wr = |mem_o.wr_strb;
    a_strobe_has_req: assert property (wr |-> $past(req_i.valid && req_i.write))
        else $error("strobe without write request");
    a_word_both_lanes: assert property (wr && !$past(req_i.is_byte) |-> mem_o.wr_strb == DSAU_STRB_BOTH)
        else $error("word write lacks a lane");
    a_byte_lane_match: assert property (wr && $past(req_i.is_byte) |->
        mem_o.wr_strb == (mem_o.xaddr[0] ? DSAU_STRB_HI : DSAU_STRB_LO))
        else $error("byte write on wrong lane");
    a_misaligned_no_write: assert property (wr && !$past(req_i.is_byte) |-> !mem_o.xaddr[0])
        else $error("odd word write reached memory");
    a_write_page_join: assert property (wr |-> mem_o.xaddr[23:16] == $past(write_page_reg_i))
        else $error("write page not joined");
    a_read_page_join: assert property (mem_o.rd |-> mem_o.xaddr[23:16] == $past(read_page_reg_i))
        else $error("read page not joined");
    a_word_addr_even: assert property (mem_o.rd || wr |-> mem_o.word_addr == {mem_o.xaddr[15:1], 1'b0})
        else $error("word address not the even pair");
    a_read_then_valid: assert property (mem_o.rd |=> rvalid_o)
        else $error("read result missing");
    a_outside_zero: assert property (rvalid_o && mem_o.xaddr[15:0] > DSAU_RAM_HI |-> rdata_o[7:0] == 8'h00)
        else $error("unimplemented read not zero");
    a_trap_one_pulse: assert property (addr_error_trap_o |=> !addr_error_trap_o)
        else $error("trap longer than a pulse");
    c_word_write: cover property (mem_o.wr_strb == DSAU_STRB_BOTH);
    c_read_done: cover property (rvalid_o);
    c_trap: cover property (addr_error_trap_o);
    c_byte_write: cover property (mem_o.wr_strb == DSAU_STRB_HI);
endmodule

bind dsau_core dsau_core_chk u_chk (.clk_i, .sys_rst_i, .clk_en_i, .req_i, .read_page_reg_i, .write_page_reg_i,
    .mem_o, .rdata_o, .rvalid_o, .addr_error_trap_o);

// File: dsau_mem_model.sv
// RAM and special register model behind the unit
`timescale 1ns/100ps
module dsau_mem_model
    import dsau_pkg::*;
(
    input  wire logic      clk_i,
    input  wire dsau_mem_t mem_i,
    output logic [15:0]    rdata_o,
    output logic           hit_o
);
    logic [15:0] ram [16];
    logic [15:0] last = 16'h5a5a;
    initial for (int i = 0; i < 16; i++) ram[i] = 16'h1111 * (i[15:0] + 16'h0001);
    // Small array aliases every address, so the unit must mask unimplemented ones
    always @(posedge clk_i) begin
        if (mem_i.rd) last <= rdata_o;
        if (mem_i.wr_strb[0]) ram[mem_i.word_addr[4:1]][7:0] <= mem_i.wdata[7:0];
        if (mem_i.wr_strb[1]) ram[mem_i.word_addr[4:1]][15:8] <= mem_i.wdata[15:8];
    end
    // Data answers while the read strobe stands; otherwise flipped stale data
    assign rdata_o = mem_i.rd ? ram[mem_i.word_addr[4:1]] : ~last;
    assign hit_o = mem_i.rd && (mem_i.word_addr < 16'h0f00);
endmodule

// File: data_space_access_unit_test.sv
// Testbench of the data space access unit
`timescale 1ns/100ps
module data_space_access_unit_test
    import dsau_pkg::*;
;
    logic        clk_i = 0, sys_rst_i = 1, clk_en_i = 1;
    dsau_req_t   req_i = '0;
    logic [7:0]  read_page_reg_i = 8'h07, write_page_reg_i = 8'h05;
    logic [15:0] mem_rdata_i, dest_old_i = 16'h5500, rdata_o, work_reg_o, next_pointer_o, ptr_seen;
    logic        special_hit_i, rvalid_o, pointer_we_o, addr_error_trap_o;
    dsau_ext_t   ext_i = DSAU_EXT_NONE;
    dsau_mem_t   mem_o;
    int          n_mismatch = 0, checked = 0;
    dsau_core dut (.clk_i, .sys_rst_i, .clk_en_i, .req_i, .read_page_reg_i, .write_page_reg_i, .mem_rdata_i,
        .special_hit_i, .dest_old_i, .ext_i, .mem_o, .rdata_o, .rvalid_o, .work_reg_o, .next_pointer_o,
        .pointer_we_o, .addr_error_trap_o);
    dsau_mem_model mem (.clk_i, .mem_i(mem_o), .rdata_o(mem_rdata_i), .hit_o(special_hit_i));
    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (pointer_we_o) ptr_seen <= next_pointer_o;
    task automatic chk(string what, logic [23:0] seen, logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic go(logic w, logic b, dsau_mode_t m, logic [15:0] a, logic [15:0] d);
        @(negedge clk_i);
        req_i = '{valid: 1'b1, write: w, is_byte: b, mode: m, direct_addr: a, source_work_reg: a, wdata: d};
        @(negedge clk_i);
        req_i.valid = 1'b0;
    endtask
    task automatic rd(logic b, dsau_mode_t m, logic [15:0] a, logic [15:0] ea, logic [15:0] exp);
        go(0, b, m, a, 16'h0000);
        chk("rd_xaddr", mem_o.xaddr, {read_page_reg_i, ea});
        @(negedge clk_i);
        chk("rdata", rdata_o, exp);
    endtask
    task automatic t_write();
        go(1, 0, DSAU_MODE_DIRECT16, 16'h1002, 16'h1234);
        chk("word_strb", mem_o.wr_strb, DSAU_STRB_BOTH);
        chk("wr_xaddr", mem_o.xaddr, {write_page_reg_i, 16'h1002});
        go(1, 1, DSAU_MODE_DIRECT16, 16'h1003, 16'habab);
        chk("byte_strb", mem_o.wr_strb, DSAU_STRB_HI);
        chk("byte_wdata", mem_o.wdata, 16'habab);
        rd(0, DSAU_MODE_DIRECT16, 16'h1002, 16'h1002, 16'hab34);
    endtask
    task automatic t_read();
        rd(1, DSAU_MODE_DIRECT16, 16'h1003, 16'h1003, 16'h55ab);
        chk("work_reg", work_reg_o, 16'h55ab);
        rd(0, DSAU_MODE_DIRECT16, 16'he002, 16'he002, 16'h0000);
        rd(0, DSAU_MODE_DIRECT16, 16'h0f10, 16'h0f10, 16'h0000);
        rd(0, DSAU_MODE_DIRECT16, 16'h0004, 16'h0004, 16'h3333);
        rd(0, DSAU_MODE_NEAR13, 16'hf004, 16'h1004, 16'h3333);
        rd(0, DSAU_MODE_INDIRECT, 16'h1004, 16'h1004, 16'h3333);
    endtask
    task automatic t_misalign();
        go(1, 0, DSAU_MODE_DIRECT16, 16'h1005, 16'hffff);
        chk("odd_strb", mem_o.wr_strb, DSAU_STRB_NONE);
        @(negedge clk_i);
        chk("wr_trap", addr_error_trap_o, 1'b1);
        go(0, 0, DSAU_MODE_DIRECT16, 16'h1005, 16'h0000);
        @(negedge clk_i);
        chk("rd_done", rvalid_o, 1'b1);
        @(negedge clk_i);
        chk("rd_trap", addr_error_trap_o, 1'b1);
        rd(0, DSAU_MODE_DIRECT16, 16'h1004, 16'h1004, 16'h3333);
    endtask
    task automatic t_ptr(logic b, logic [15:0] exp, logic [15:0] step);
        ptr_seen = 16'h0000;
        rd(b, DSAU_MODE_POSTINC, 16'h1010, 16'h1010, exp);
        @(negedge clk_i);
        chk("pointer", ptr_seen, 16'h1010 + step);
    endtask
    task automatic t_ext(dsau_ext_t e, logic [15:0] exp);
        dest_old_i = 16'h1280;
        ext_i = e;
        @(negedge clk_i);
        ext_i = DSAU_EXT_NONE;
        chk("extend", work_reg_o, exp);
    endtask
    task automatic t_freeze();
        clk_en_i = 0;
        dest_old_i = 16'h12f0;
        ext_i = DSAU_EXT_SIGN;
        @(negedge clk_i);
        ext_i = DSAU_EXT_NONE;
        clk_en_i = 1;
        chk("frozen", work_reg_o, 16'h0080);
    endtask
    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (10) @(negedge clk_i);
        sys_rst_i = 0;
        t_write();
        t_read();
        t_misalign();
        t_ptr(1, 16'h5599, DSAU_INC_BYTE);
        t_ptr(0, 16'h9999, DSAU_INC_WORD);
        t_ext(DSAU_EXT_SIGN, 16'hff80);
        t_ext(DSAU_EXT_ZERO, 16'h0080);
        t_freeze();
        print_verdict();
    end
endmodule
